// ---- rtl/uart_pkg.sv ----
/*
  shared constants and the character parity function of the serial port.
  assumes registers are one aligned 32-bit word each on an ahb-lite bus.
*/
package uart_pkg;
  // register byte offsets (low address byte only)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIV = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_RXDATA = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_INT_STAT = 8'h14;
  localparam logic [7:0] OFS_INT_MASK = 8'h18;
  // control register fields
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_RX_EN = 1;
  localparam int CTRL_BITS_LO = 2;
  localparam int CTRL_TWO_STOP = 4;
  localparam int CTRL_PAR_LO = 5;
  localparam int CTRL_PAR_SEL = 7;
  localparam int CTRL_FLOW_EN = 8;
  localparam int CTRL_BREAK = 9;
  localparam int CTRL_CLK_SEL = 10;
  localparam int CTRL_DMA_FULL = 11;
  localparam int CTRL_W = 12;
  localparam logic [11:0] CTRL_RST = 12'h00F;
  localparam logic [15:0] DIV_RST = 16'h0001;
  // parity modes, two bits at CTRL_PAR_LO
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_NORMAL = 2'h1;
  localparam logic [1:0] PAR_FORCED = 2'h2;
  localparam logic [1:0] PAR_MULTIDROP = 2'h3;
  // data word fields of tx and rx data registers
  localparam int DATA_ADDR_MARK = 8;
  localparam int RX_PAR_ERR = 9;
  localparam int RX_FRM_ERR = 10;
  localparam int RX_BREAK = 11;
  localparam int RX_ENTRY_W = 12;
  // interrupt status bits
  localparam int EV_RX_READY = 0;
  localparam int EV_TX_EMPTY = 1;
  localparam int EV_OVERRUN = 2;
  localparam int EV_PAR_ERR = 3;
  localparam int EV_FRM_ERR = 4;
  localparam int EV_BREAK = 5;
  localparam int EV_W = 6;
  // sizes and clocking
  localparam int RX_DEPTH = 3;
  localparam logic [4:0] PREDIV_LAST = 5'h1F; // system clock divided by 32
  localparam real CLK_PERIOD_NS = 5.0;

  // even parity over the 5..8 active data bits
  function automatic logic char_parity(input logic [7:0] d, input logic [1:0] bits);
    logic [7:0] m;
    m = ~(8'hE0 << bits);
    return ^(d & m);
  endfunction
endpackage

// ---- rtl/uart_rx_deser.sv ----
/*
  receive shift register: finds the start edge and samples mid-bit.
  assumes i_tick is one-cycle source clock pulses and i_div is at least 1.
*/
`timescale 1ns/10ps
module uart_rx_deser (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_en,
  input wire logic i_tick,
  input wire logic [15:0] i_div,
  input wire logic [1:0] i_bits,
  input wire logic i_par_on,
  input wire logic i_rxd,
  output logic o_done,
  output logic [7:0] o_data,
  output logic o_par_bit,
  output logic o_stop_ok
);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_HOLD} rx_state_e;
  rx_state_e state_reg;
  logic [15:0] cnt_reg;
  logic [2:0] idx_reg;
  wire sample = i_tick && (cnt_reg == 16'h0000);
  wire [2:0] last_idx = 3'(3'h4 + {1'b0, i_bits});

  // sampling sequencer, start bit checked at its middle
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      state_reg <= RX_IDLE;
      cnt_reg <= 16'h0000;
      idx_reg <= 3'h0;
      o_done <= 1'b0;
      o_data <= 8'h00;
      o_par_bit <= 1'b0;
      o_stop_ok <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_tick && cnt_reg != 16'h0000) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
      unique case (state_reg)
        RX_IDLE: if (i_en && i_tick && !i_rxd) begin
          cnt_reg <= i_div >> 1;
          o_data <= 8'h00;
          o_par_bit <= 1'b0;
          idx_reg <= 3'h0;
          state_reg <= RX_START;
        end
        RX_START: if (sample) begin
          cnt_reg <= i_div - 16'h0001;
          state_reg <= i_rxd ? RX_IDLE : RX_DATA; // glitch rejected
        end
        RX_DATA: if (sample) begin
          cnt_reg <= i_div - 16'h0001;
          o_data[idx_reg] <= i_rxd;
          idx_reg <= idx_reg + 3'h1;
          if (idx_reg == last_idx) begin
            state_reg <= i_par_on ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: if (sample) begin
          cnt_reg <= i_div - 16'h0001;
          o_par_bit <= i_rxd;
          state_reg <= RX_STOP;
        end
        RX_STOP: if (sample) begin
          o_stop_ok <= i_rxd;
          o_done <= 1'b1;
          state_reg <= i_rxd ? RX_IDLE : RX_HOLD;
        end
        RX_HOLD: if (i_rxd) begin
          state_reg <= RX_IDLE; // wait out a break before rearming
        end
        default: state_reg <= RX_IDLE;
      endcase
    end
  end
endmodule

// ---- rtl/uart_top.sv ----
/*
  asynchronous serial port with rts/cts flow control, ahb-lite registers,
  a three-deep receive queue, one transmit holding register and dma requests.
  assumes a single ahb-lite master, single word transfers, inputs synchronous.
*/
`timescale 1ns/10ps
// Contract
// - baud source is system clock divided by 32 or the timer clock input.
// - bit rate is the source clock divided by a 16-bit divisor.
// - rts out and cts in let each side hold off the other sender.
// - data bits per character are five, six, seven or eight.
// - stop bits per transmitted character are selectable by software.
// - parity off, even, odd, or forced to a software value.
// - break is sent for as long as software holds it.
// - received break is detected and reported in the receive data word and interrupt status.
// - framing, parity and overrun errors are flagged.
// - receive path is a shift register plus three queued holding registers.
// - transmit path is a shift register plus one holding register.
// - multidrop mode uses the parity position as address or data mark.
// - dma requests on receive full or not empty, and transmit empty.
module uart_top (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_rxd,
  output logic o_txd,
  input wire logic i_clear_to_send_in,
  output logic o_request_to_send_out,
  input wire logic i_timer_clock_input,
  output logic o_irq,
  output logic o_dma_rx_req,
  output logic o_dma_tx_req
);
  // registers
  logic [uart_pkg::CTRL_W-1:0] ctrl_reg;
  logic [15:0] div_reg;
  logic [uart_pkg::EV_W-1:0] int_stat_reg;
  logic [uart_pkg::EV_W-1:0] int_stat_next;
  logic [uart_pkg::EV_W-1:0] int_mask_reg;
  logic [8:0] tx_hold_reg;
  logic tx_full_reg;
  logic [uart_pkg::RX_ENTRY_W-1:0] rx_q_reg [uart_pkg::RX_DEPTH];
  logic [1:0] rx_cnt_reg;
  logic [4:0] prediv_reg;
  logic tmr_prev_reg;
  // bus data phase
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;

  // control field views
  wire tx_en = ctrl_reg[uart_pkg::CTRL_TX_EN];
  wire rx_en = ctrl_reg[uart_pkg::CTRL_RX_EN];
  wire [1:0] bits = ctrl_reg[uart_pkg::CTRL_BITS_LO +: 2];
  wire two_stop = ctrl_reg[uart_pkg::CTRL_TWO_STOP];
  wire [1:0] par_mode = ctrl_reg[uart_pkg::CTRL_PAR_LO +: 2];
  wire par_sel = ctrl_reg[uart_pkg::CTRL_PAR_SEL];
  wire flow_en = ctrl_reg[uart_pkg::CTRL_FLOW_EN];
  wire brk_en = ctrl_reg[uart_pkg::CTRL_BREAK];
  wire clk_sel = ctrl_reg[uart_pkg::CTRL_CLK_SEL];
  wire dma_full = ctrl_reg[uart_pkg::CTRL_DMA_FULL];
  wire par_on = (par_mode != uart_pkg::PAR_NONE);
  wire [15:0] div_eff = (div_reg == 16'h0000) ? 16'h0001 : div_reg;

  // address phase decode
  wire addr_ok = i_hsel && i_htrans[1] && i_hready;
  wire rd_acc = addr_ok && !i_hwrite;
  wire wr_acc = wr_pend_reg && i_hready;
  wire [7:0] ra = i_haddr[7:0];
  wire wr_ctrl = wr_acc && (wr_addr_reg == uart_pkg::OFS_CTRL);
  wire wr_div = wr_acc && (wr_addr_reg == uart_pkg::OFS_DIV);
  wire wr_tx = wr_acc && (wr_addr_reg == uart_pkg::OFS_TXDATA);
  wire wr_istat = wr_acc && (wr_addr_reg == uart_pkg::OFS_INT_STAT);
  wire wr_imask = wr_acc && (wr_addr_reg == uart_pkg::OFS_INT_MASK);
  wire rd_rx = rd_acc && (ra == uart_pkg::OFS_RXDATA);

  // baud source: prescaler by 32 or a timer input rising edge
  wire tmr_edge = i_timer_clock_input && !tmr_prev_reg;
  wire pre_tick = (prediv_reg == uart_pkg::PREDIV_LAST);
  wire src_tick = clk_sel ? tmr_edge : pre_tick;

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      prediv_reg <= 5'h00;
      tmr_prev_reg <= 1'b0;
    end else begin
      prediv_reg <= prediv_reg + 5'h01;
      tmr_prev_reg <= i_timer_clock_input;
    end
  end

  // transmit side: holding register feeds the shifter
  logic tx_busy;
  logic tx_line;
  wire tx_par_norm = uart_pkg::char_parity(tx_hold_reg[7:0], bits) ^ par_sel;
  wire tx_mark = tx_hold_reg[uart_pkg::DATA_ADDR_MARK];
  wire tx_par_val = (par_mode == uart_pkg::PAR_MULTIDROP) ? tx_mark :
                    (par_mode == uart_pkg::PAR_FORCED) ? par_sel : tx_par_norm;
  wire cts_ok = !flow_en || i_clear_to_send_in;
  wire tx_load = tx_en && tx_full_reg && !tx_busy && !brk_en && cts_ok;

  uart_tx_ser u_tx (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_tick(src_tick),
    .i_div(div_eff),
    .i_bits(bits),
    .i_par_on(par_on),
    .i_par_val(tx_par_val),
    .i_two_stop(two_stop),
    .i_break(brk_en),
    .i_load(tx_load),
    .i_data(tx_hold_reg[7:0]),
    .o_busy(tx_busy),
    .o_txd(tx_line)
  );
  assign o_txd = tx_line;

  // holding register fill and drain; a write while full is dropped
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      tx_hold_reg <= 9'h000;
      tx_full_reg <= 1'b0;
    end else if (wr_tx && !tx_full_reg) begin
      tx_hold_reg <= i_hwdata[8:0];
      tx_full_reg <= 1'b1;
    end else if (tx_load) begin
      tx_full_reg <= 1'b0;
    end
  end

  // receive side
  logic rx_done;
  logic [7:0] rx_data;
  logic rx_par_bit;
  logic rx_stop_ok;

  uart_rx_deser u_rx (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_en(rx_en),
    .i_tick(src_tick),
    .i_div(div_eff),
    .i_bits(bits),
    .i_par_on(par_on),
    .i_rxd(i_rxd),
    .o_done(rx_done),
    .o_data(rx_data),
    .o_par_bit(rx_par_bit),
    .o_stop_ok(rx_stop_ok)
  );

  // error and mark decode of a finished character
  wire rx_exp_par = (par_mode == uart_pkg::PAR_FORCED) ? par_sel :
                    uart_pkg::char_parity(rx_data, bits) ^ par_sel;
  wire rx_brk = (rx_data == 8'h00) && !rx_par_bit && !rx_stop_ok;
  wire rx_ferr = !rx_stop_ok && !rx_brk;
  wire rx_perr = par_on && (par_mode != uart_pkg::PAR_MULTIDROP) &&
                 (rx_par_bit != rx_exp_par) && !rx_brk;
  wire rx_mark = (par_mode == uart_pkg::PAR_MULTIDROP) && rx_par_bit;
  wire [uart_pkg::RX_ENTRY_W-1:0] rx_entry = {rx_brk, rx_ferr, rx_perr, rx_mark, rx_data};

  // queue control: pop on read of the data register, push on a character
  wire rx_pop = rd_rx && (rx_cnt_reg != 2'h0);
  wire rx_full = (rx_cnt_reg == 2'(uart_pkg::RX_DEPTH));
  wire rx_push = rx_done && (!rx_full || rx_pop);
  wire rx_ovr = rx_done && rx_full && !rx_pop;
  wire [1:0] wr_slot = 2'(rx_cnt_reg - {1'b0, rx_pop});

  // three holding registers as a shifting queue, head at slot 0
  genvar g;
  generate
    for (g = 0; g < uart_pkg::RX_DEPTH; g++) begin : g_rxq
      always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
          rx_q_reg[g] <= '0;
        end else if (rx_push && wr_slot == 2'(g)) begin
          rx_q_reg[g] <= rx_entry;
        end else if (rx_pop) begin
          rx_q_reg[g] <= (g + 1 < uart_pkg::RX_DEPTH) ?
                         rx_q_reg[(g + 1) % uart_pkg::RX_DEPTH] : '0;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      rx_cnt_reg <= 2'h0;
    end else begin
      rx_cnt_reg <= 2'(rx_cnt_reg + {1'b0, rx_push} - {1'b0, rx_pop});
    end
  end

  // rts drops with two queued so a character in flight still fits
  assign o_request_to_send_out = !flow_en || (rx_cnt_reg < 2'h2);

  // dma requests
  assign o_dma_rx_req = dma_full ? rx_full : (rx_cnt_reg != 2'h0);
  assign o_dma_tx_req = tx_en && !tx_full_reg;

  // sticky events, a new event wins over a write-one clear
  wire [uart_pkg::EV_W-1:0] ev_set = {
    rx_done && rx_brk,
    rx_done && rx_ferr,
    rx_done && rx_perr,
    rx_ovr,
    tx_load,
    rx_push
  };
  wire [uart_pkg::EV_W-1:0] ev_clr = wr_istat ? i_hwdata[uart_pkg::EV_W-1:0] : '0;
  assign int_stat_next = (int_stat_reg & ~ev_clr) | ev_set;
  assign o_irq = |(int_stat_reg & int_mask_reg);

  // software registers
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      ctrl_reg <= uart_pkg::CTRL_RST;
      div_reg <= uart_pkg::DIV_RST;
      int_mask_reg <= '0;
      int_stat_reg <= '0;
    end else begin
      int_stat_reg <= int_stat_next;
      if (wr_ctrl) begin
        ctrl_reg <= i_hwdata[uart_pkg::CTRL_W-1:0];
      end
      if (wr_div) begin
        div_reg <= i_hwdata[15:0];
      end
      if (wr_imask) begin
        int_mask_reg <= i_hwdata[uart_pkg::EV_W-1:0];
      end
    end
  end

  // status word
  wire [31:0] status_word = {24'h000000, o_request_to_send_out, i_clear_to_send_in,
                             rx_cnt_reg, rx_full, (rx_cnt_reg != 2'h0),
                             !tx_busy && !tx_full_reg, !tx_full_reg};

  // read mux
  wire [31:0] rd_mux =
    (ra == uart_pkg::OFS_CTRL) ? {20'h00000, ctrl_reg} :
    (ra == uart_pkg::OFS_DIV) ? {16'h0000, div_reg} :
    (ra == uart_pkg::OFS_RXDATA) ? {20'h00000, rx_q_reg[0]} :
    (ra == uart_pkg::OFS_STATUS) ? status_word :
    (ra == uart_pkg::OFS_INT_STAT) ? {26'h0000000, int_stat_reg} :
    (ra == uart_pkg::OFS_INT_MASK) ? {26'h0000000, int_mask_reg} : 32'h00000000;

  // bus slave: zero wait states, read data registered into the data phase
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      o_hrdata <= 32'h00000000;
    end else if (i_hready) begin
      wr_pend_reg <= addr_ok && i_hwrite;
      wr_addr_reg <= ra;
      if (rd_acc) begin
        o_hrdata <= rd_mux;
      end
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
endmodule

// ---- rtl/uart_tx_ser.sv ----
/*
  transmit shift register: start, lsb-first data, optional parity, stops.
  assumes i_tick is one-cycle source clock pulses and i_div is at least 1.
*/
`timescale 1ns/10ps
module uart_tx_ser (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_tick,
  input wire logic [15:0] i_div,
  input wire logic [1:0] i_bits,
  input wire logic i_par_on,
  input wire logic i_par_val,
  input wire logic i_two_stop,
  input wire logic i_break,
  input wire logic i_load,
  input wire logic [7:0] i_data,
  output logic o_busy,
  output logic o_txd
);
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_e;
  tx_state_e state_reg;
  logic [15:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [2:0] idx_reg;
  logic par_reg;
  logic stop2_reg;
  logic line_reg;
  wire bit_end = i_tick && (cnt_reg == 16'h0000);
  wire [2:0] last_idx = 3'(3'h4 + {1'b0, i_bits});

  assign o_busy = (state_reg != TX_IDLE);
  assign o_txd = line_reg & ~i_break; // forced low for as long as break is set

  // bit sequencer, one bit lasts i_div source ticks
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      state_reg <= TX_IDLE;
      cnt_reg <= 16'h0000;
      sh_reg <= 8'h00;
      idx_reg <= 3'h0;
      par_reg <= 1'b0;
      stop2_reg <= 1'b0;
      line_reg <= 1'b1;
    end else begin
      if (i_tick && cnt_reg != 16'h0000) begin
        cnt_reg <= cnt_reg - 16'h0001;
      end
      unique case (state_reg)
        TX_IDLE: begin
          line_reg <= 1'b1; // idle high
          if (i_load) begin
            sh_reg <= i_data;
            par_reg <= i_par_val;
            stop2_reg <= i_two_stop;
            idx_reg <= 3'h0;
            cnt_reg <= i_div - 16'h0001;
            line_reg <= 1'b0; // start bit low
            state_reg <= TX_START;
          end
        end
        TX_START: if (bit_end) begin
          cnt_reg <= i_div - 16'h0001;
          line_reg <= sh_reg[0]; // lsb first
          state_reg <= TX_DATA;
        end
        TX_DATA: if (bit_end) begin
          cnt_reg <= i_div - 16'h0001;
          if (idx_reg == last_idx) begin
            line_reg <= i_par_on ? par_reg : 1'b1;
            state_reg <= i_par_on ? TX_PAR : TX_STOP;
          end else begin
            idx_reg <= idx_reg + 3'h1;
            line_reg <= sh_reg[3'(idx_reg + 3'h1)];
          end
        end
        TX_PAR: if (bit_end) begin
          cnt_reg <= i_div - 16'h0001;
          line_reg <= 1'b1;
          state_reg <= TX_STOP;
        end
        TX_STOP: if (bit_end) begin
          cnt_reg <= i_div - 16'h0001;
          if (stop2_reg) begin
            stop2_reg <= 1'b0; // second stop bit
          end else begin
            state_reg <= TX_IDLE;
          end
        end
        default: state_reg <= TX_IDLE;
      endcase
    end
  end
endmodule

// ---- verification/serial_station.sv ----
/*
  remote serial station: sends frames on the receive line, samples the transmit line.
  assumes the bench sets bit_clks to one bit time in system clocks.
*/
`timescale 1ns/10ps
module serial_station (
  input wire logic i_mclk,
  input wire logic i_txd,
  input wire logic i_rts,
  output logic o_rxd,
  output logic o_cts
);
  int bit_clks = 128;
  bit obey_rts = 1'b1;
  // line idles high, sending permitted
  initial begin
    o_rxd = 1'b1;
    o_cts = 1'b1;
  end
  // low start bit, then n bits lsb first, then idle high
  task automatic send(input logic [11:0] f, input int n);
    @(posedge i_mclk);
    while (obey_rts && i_rts !== 1'b1) @(posedge i_mclk); // held off
    o_rxd <= 1'b0;
    for (int k = 0; k <= n + 1; k++) begin
      repeat (bit_clks) @(posedge i_mclk);
      o_rxd <= (k >= n) ? 1'b1 : f[k];
    end
  endtask
  // finds a start bit, then samples n bits at their middles
  task automatic recv(input int n, output logic [11:0] f);
    f = 12'hFFF;
    @(posedge i_mclk);
    while (i_txd !== 1'b0) @(posedge i_mclk);
    repeat (bit_clks / 2) @(posedge i_mclk);
    for (int k = 0; k < n; k++) begin
      repeat (bit_clks) @(posedge i_mclk);
      f[k] = i_txd;
    end
  endtask
endmodule

// ---- verification/testbench.sv ----
/*
  self-checking bench: bus tasks, formats both ways, errors, queue, flow, break, irq.
  assumes the serial station model and the checker are compiled alongside.
*/
`timescale 1ns/10ps
module testbench;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic tmr = 1'b0;
  logic [1:0] tcnt = 2'h0;
  wire [31:0] hrdata;
  wire hready, hresp, rxd, txd, cts, rts, irq, dma_rx, dma_tx;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  int nb, pm, ps;
  logic [11:0] ctl = 12'h00F;
  logic [11:0] f;
  logic [31:0] q;

  uart_top u_uart_top (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_rxd(rxd), .o_txd(txd), .i_clear_to_send_in(cts), .o_request_to_send_out(rts),
    .i_timer_clock_input(tmr), .o_irq(irq), .o_dma_rx_req(dma_rx), .o_dma_tx_req(dma_tx));
  serial_station u_serial_station (.i_mclk(i_mclk), .i_txd(txd), .i_rts(rts), .o_rxd(rxd),
    .o_cts(cts));

  initial begin
    forever #2.5 i_mclk = ~i_mclk;
  end
  // timer clock rising every fourth cycle; run ceiling
  always @(posedge i_mclk) begin
    tcnt <= tcnt + 2'h1;
    tmr <= tcnt[1];
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (err_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      err_count++;
    end
  endtask
  // one single word transfer: address phase, then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge i_mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge i_mclk);
    while (hready !== 1'b1) @(posedge i_mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge i_mclk);
    while (hready !== 1'b1) @(posedge i_mclk);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0);
    cmp(q, exp);
  endtask
  task automatic setc();
    bus(uart_pkg::OFS_CTRL, 1'b1, {20'h0, ctl});
  endtask
  // bits after the start bit: data lsb first, parity or mark, stops
  function automatic logic [11:0] frame(input logic [7:0] d, input int n, input int m,
      input int s);
    logic [11:0] r;
    r = 12'hFFF;
    for (int k = 0; k < n; k++) r[k] = d[k];
    if (m != 0) r[n] = (m == 1) ? (^(d & ~(8'hFF << n)) ^ s[0]) : s[0];
    return r;
  endfunction
  // one character out and the same frame back in
  task automatic both(input logic [7:0] d);
    int n;
    logic [11:0] e;
    n = nb + (pm != 0) + 1 + ctl[4];
    e = frame(d, nb, pm, ps);
    bus(uart_pkg::OFS_TXDATA, 1'b1, {23'h0, ps[0], d});
    u_serial_station.recv(n, f);
    cmp(f, e);
    u_serial_station.send(e, n);
    rd(uart_pkg::OFS_RXDATA, {23'h0, ps[0] & (pm == 3), d & ~(8'hFF << nb)});
  endtask

  initial begin
    repeat (16) @(posedge i_mclk);
    i_rstn <= 1'b1;
    rd(uart_pkg::OFS_CTRL, 32'h00F);
    rd(uart_pkg::OFS_STATUS, 32'hC3);
    rd(uart_pkg::OFS_INT_MASK, 32'h0);
    rd(uart_pkg::OFS_INT_STAT, 32'h0);
    rd(uart_pkg::OFS_RXDATA, 32'h0);
    bus(8'h1C, 1'b1, 32'hFFFF_FFFF);
    rd(8'h1C, 32'h0);
    rd(uart_pkg::OFS_TXDATA, 32'h0);
    cmp({dma_tx, dma_rx, irq, rts, txd}, 5'b10011);
    rd(uart_pkg::OFS_DIV, 32'h1);
    bus(uart_pkg::OFS_DIV, 1'b1, 32'h0001_FFFF);
    rd(uart_pkg::OFS_DIV, 32'hFFFF);
    bus(uart_pkg::OFS_DIV, 1'b1, 32'h4);
    nb = 8;
    pm = 0;
    ps = 0;
    both(8'hA5);
    // timer clock source, every width, parity mode and stop count
    u_serial_station.bit_clks = 16;
    ctl[10] = 1'b1;
    for (nb = 5; nb <= 8; nb++) begin
      for (pm = 0; pm < 4; pm++) begin
        for (ps = 0; ps < 2; ps++) begin
          ctl[3:2] = 2'(nb - 5);
          ctl[4] = ps[0] ^ nb[0];
          ctl[6:5] = 2'(pm);
          ctl[7] = ps[0];
          setc();
          both(8'(8'h3C + nb * 16 + pm * 4 + ps));
        end
      end
    end
    // parity error, low stop bit, then a break
    ctl = 12'h42F;
    setc();
    bus(uart_pkg::OFS_INT_STAT, 1'b1, 32'h3F);
    u_serial_station.send(frame(8'h3C, 8, 1, 1), 10);
    rd(uart_pkg::OFS_RXDATA, 32'h23C);
    u_serial_station.send(frame(8'h5A, 8, 1, 0) & 12'h1FF, 10);
    rd(uart_pkg::OFS_RXDATA, 32'h45A);
    u_serial_station.send(12'h0, 10);
    rd(uart_pkg::OFS_RXDATA, 32'h800);
    rd(uart_pkg::OFS_INT_STAT, 32'h39);
    // four characters into a three deep queue
    bus(uart_pkg::OFS_INT_STAT, 1'b1, 32'h3F);
    u_serial_station.obey_rts = 1'b0;
    bus(uart_pkg::OFS_CTRL, 1'b1, 32'h42D);
    u_serial_station.send(12'h0, 10);
    setc();
    for (nb = 1; nb < 5; nb++) u_serial_station.send(frame(8'(nb), 8, 1, 0), 10);
    bus(uart_pkg::OFS_STATUS, 1'b0, 32'h0);
    cmp(q & 32'h7F, 32'h7F);
    rd(uart_pkg::OFS_INT_STAT, 32'h05);
    cmp(dma_rx, 1'b1);
    ctl[11] = 1'b1;
    setc();
    cmp(dma_rx, 1'b1);
    for (nb = 1; nb < 4; nb++) begin
      rd(uart_pkg::OFS_RXDATA, nb);
      cmp(dma_rx, 1'b0);
    end
    // receive hold-off with flow control
    ctl = 12'h52F;
    setc();
    u_serial_station.obey_rts = 1'b1;
    u_serial_station.send(frame(8'h71, 8, 1, 0), 10);
    cmp({rts, dma_rx}, 2'b11);
    u_serial_station.send(frame(8'h72, 8, 1, 0), 10);
    cmp(rts, 1'b0);
    rd(uart_pkg::OFS_RXDATA, 32'h71);
    cmp(rts, 1'b1);
    rd(uart_pkg::OFS_RXDATA, 32'h72);
    // send held by cts; second word dropped while holding full
    u_serial_station.o_cts <= 1'b0;
    bus(uart_pkg::OFS_TXDATA, 1'b1, 32'h11);
    bus(uart_pkg::OFS_TXDATA, 1'b1, 32'h22);
    repeat (64) @(posedge i_mclk);
    cmp({txd, dma_tx}, 2'b10);
    rd(uart_pkg::OFS_STATUS, 32'h80);
    u_serial_station.o_cts <= 1'b1;
    u_serial_station.recv(10, f);
    cmp(f, frame(8'h11, 8, 1, 0));
    repeat (48) @(posedge i_mclk);
    rd(uart_pkg::OFS_STATUS, 32'hC3);
    // back to back words through holding and shift registers
    bus(uart_pkg::OFS_TXDATA, 1'b1, 32'h81);
    bus(uart_pkg::OFS_TXDATA, 1'b1, 32'h42);
    u_serial_station.recv(10, f);
    cmp(f, frame(8'h81, 8, 1, 0));
    u_serial_station.recv(10, f);
    cmp(f, frame(8'h42, 8, 1, 0));
    // break lasts as long as the control bit
    ctl[9] = 1'b1;
    setc();
    repeat (100) @(posedge i_mclk);
    cmp(txd, 1'b0);
    ctl[9] = 1'b0;
    setc();
    @(posedge i_mclk);
    cmp(txd, 1'b1);
    // interrupt raised, cleared, masked and unmasked
    bus(uart_pkg::OFS_INT_STAT, 1'b1, 32'h3F);
    bus(uart_pkg::OFS_INT_MASK, 1'b1, 32'h01);
    rd(uart_pkg::OFS_INT_MASK, 32'h01);
    u_serial_station.send(frame(8'h99, 8, 1, 0), 10);
    cmp(irq, 1'b1);
    bus(uart_pkg::OFS_INT_STAT, 1'b1, 32'h01);
    @(posedge i_mclk);
    cmp(irq, 1'b0);
    bus(uart_pkg::OFS_INT_MASK, 1'b1, 32'h0);
    u_serial_station.send(frame(8'h66, 8, 1, 0), 10);
    cmp(irq, 1'b0);
    rd(uart_pkg::OFS_INT_STAT, 32'h01);
    bus(uart_pkg::OFS_INT_MASK, 1'b1, 32'h01);
    @(posedge i_mclk);
    cmp(irq, 1'b1);
    stop_test();
  end
endmodule

// ---- verification/uart_assertions.sv ----
/*
  concurrent checks on the serial port's bus answers, serial line and requests.
  assumes it is bound to uart_top and sees only that module's ports.
*/
`timescale 1ns/10ps
module uart_checker (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic o_txd,
  input wire logic o_request_to_send_out,
  input wire logic o_irq,
  input wire logic o_dma_rx_req,
  input wire logic o_dma_tx_req
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  // address phases taken, queue pops and write data phases
  wire take = i_hsel & i_htrans[1] & i_hready;
  wire rd_take = take & ~i_hwrite;
  wire pop = rd_take & (i_haddr[7:0] == uart_pkg::OFS_RXDATA);
  wire no_reg = (i_haddr[7:0] > uart_pkg::OFS_INT_MASK) | (i_haddr[7:0] == uart_pkg::OFS_TXDATA);
  logic wr_dph;
  // write data phase follows a taken write address phase
  always_ff @(posedge i_mclk) begin
    wr_dph <= i_rstn & take & i_hwrite;
  end

  chk_bus_okay: assert property (o_hreadyout && !o_hresp)
    else $error("bus answer not ready or not okay");
  chk_reset_idle: assert property ($rose(i_rstn) |-> o_txd && !o_irq && !o_dma_rx_req
    && o_dma_tx_req && o_request_to_send_out)
    else $error("outputs wrong right after reset");
  chk_bit_length: assert property ($changed(o_txd) |=> $stable(o_txd) [*7])
    else $error("serial line level held too briefly");
  chk_irq_clear: assert property ($fell(o_irq) |-> $past(wr_dph))
    else $error("interrupt dropped without a register write");
  chk_dma_tx_fall: assert property ($fell(o_dma_tx_req) |-> $past(wr_dph))
    else $error("transmit request dropped without a write");
  chk_dma_rx_fall: assert property ($fell(o_dma_rx_req) |-> $past(pop) || $past(wr_dph))
    else $error("receive request dropped without a pop or write");
  chk_read_hold: assert property (!$past(rd_take) |-> $stable(o_hrdata))
    else $error("read data changed without a read");
  chk_empty_place: assert property (rd_take && no_reg |=> o_hrdata == 32'h0)
    else $error("unmapped or write-only place read nonzero");

  cov_irq: cover property ($rose(o_irq));
  cov_rts_low: cover property ($fell(o_request_to_send_out));
  cov_rx_dma: cover property ($rose(o_dma_rx_req));
endmodule

bind uart_top uart_checker u_uart_checker (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_hsel(i_hsel),
  .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
  .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .o_txd(o_txd),
  .o_request_to_send_out(o_request_to_send_out), .o_irq(o_irq),
  .o_dma_rx_req(o_dma_rx_req), .o_dma_tx_req(o_dma_tx_req));
